// ==== sft_regs.svh ====
`ifndef SFT_REGS_SVH
`define SFT_REGS_SVH

// Line characters
`define SFT_FLAG_CHAR   8'h7E
`define SFT_ABORT_CHAR  8'hFF
`define SFT_CHAR_BITS   5'h08
`define SFT_CRC_BITS    5'h10
`define SFT_LEN_BASE    5'h05

// Frame check sequence, LSB first
`define SFT_CRC_PRESET  16'hFFFF
`define SFT_CRC_POLY    16'h8408

// Ones before an inserted zero
`define SFT_STUFF_RUN   3'h5

// Underrun latch comes up set, so no check sequence is sent until cleared
`define SFT_LATCH_RESET 1'b1

`endif

// ==== sft_pkg.sv ====
package sft_pkg;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_FLAG  = 3'b001,
		ST_DATA  = 3'b010,
		ST_CRC   = 3'b011,
		ST_ABORT = 3'b100
	} sft_state_e;

endpackage

// ==== sft_crc16.sv ====
`timescale 1ns/1ps
`include "sft_regs.svh"

module sft_crc16 (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Control
	input  wire logic        preset,
	input  wire logic        calc,
	input  wire logic        emit,
	input  wire logic        din,
	// Accumulator
	output logic [15:0]      crc_q
);

	logic        feedback;
	logic [15:0] crc_next;

	assign feedback = crc_q[0] ^ din;

	always_comb begin
		crc_next = crc_q;
		if (preset) begin
			crc_next = `SFT_CRC_PRESET;
		end else if (calc) begin
			crc_next = (crc_q >> 1) ^ (feedback ? `SFT_CRC_POLY : 16'h0000);
		end else if (emit) begin
			// Shifting out drains the accumulator, low bit first
			crc_next = crc_q >> 1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			crc_q <= `SFT_CRC_PRESET;
		end else begin
			crc_q <= crc_next;
		end
	end

endmodule

// ==== sft_transmitter.sv ====
// Functional notes
// - Flags go out once transmit is enabled and clear-to-send is active.
// - No buffer-empty interrupt before the first byte; clear-to-send change comes first.
// - Each byte moved out of the buffer requests the next by interrupt or wait/ready.
// - Character length may change mid-frame; sampled as each byte is loaded.
// - Underrun with latch clear sends the check sequence, sets latch, raises interrupt.
// - After the last byte and an empty buffer: check sequence if latch clear, then closing flag.
// - Closing flag queued after check sequence raises a buffer-empty interrupt.
// - Send-abort command aborts the frame in progress.
// - Reset-check-generator command presets the accumulator to all ones.
// - External/status interrupt on clear-to-send, carrier-detect and latch changes.
`timescale 1ns/1ps
`include "sft_regs.svh"

module sft_transmitter (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Configuration
	input  wire logic       tx_enable,
	input  wire logic       tx_int_enable,
	input  wire logic       ext_int_enable,
	input  wire logic       wait_mode,
	input  wire logic [1:0] char_len,
	// Host data
	input  wire logic       host_write,
	input  wire logic [7:0] host_data,
	// Host commands, one-cycle pulses
	input  wire logic       cmd_reset_crc,
	input  wire logic       cmd_reset_underrun,
	input  wire logic       cmd_reset_tx_int,
	input  wire logic       cmd_reset_ext_int,
	input  wire logic       cmd_send_abort,
	// Modem inputs
	input  wire logic       cts_n,
	input  wire logic       dcd_n,
	// Serial line
	input  wire logic       bit_tick,
	output logic            txd,
	// Status and requests
	output logic            tx_buffer_full,
	output logic            transmit_underrun_end_latch,
	output logic            tx_int_pending,
	output logic            ext_int_pending,
	output logic            int_n,
	output logic            wait_ready_n
);

	////////////////////////////////////////////////////////////////////////////////
	sft_pkg::sft_state_e state_reg;
	sft_pkg::sft_state_e state_next;
	logic [7:0]  sh_reg;
	logic [7:0]  sh_next;
	logic [4:0]  left_reg;
	logic [4:0]  left_next;
	logic [2:0]  ones_reg;
	logic [7:0]  buf_reg;
	logic        abort_pend_reg;
	logic        armed_reg;
	logic        cts_q_reg;
	logic        dcd_q_reg;
	logic [15:0] crc_q;
	logic        latch_next;
	logic        tx_pend_next;
	logic        ext_pend_next;
	logic        txd_next;

	wire link_on   = tx_enable & ~cts_n;
	wire load_go   = (left_reg == 5'h00) & link_on & ~bit_tick;
	wire in_frame  = (state_reg == sft_pkg::ST_DATA) | (state_reg == sft_pkg::ST_CRC);

	wire take_abort    = load_go & abort_pend_reg;
	wire take_crc_end  = load_go & ~abort_pend_reg & (state_reg == sft_pkg::ST_CRC);
	wire take_data     = load_go & ~abort_pend_reg & ~take_crc_end & tx_buffer_full;
	wire take_underrun = load_go & ~abort_pend_reg & (state_reg == sft_pkg::ST_DATA)
	                   & ~tx_buffer_full & ~transmit_underrun_end_latch;
	wire take_flag     = load_go & ~take_abort & ~take_crc_end & ~take_data & ~take_underrun;

	wire emit_bit  = bit_tick & link_on & (left_reg != 5'h00);
	// Ones just before a closing flag need the zero too
	wire stuff     = emit_bit & (state_reg != sft_pkg::ST_ABORT)
	               & (ones_reg == `SFT_STUFF_RUN);
	wire shift_bit = emit_bit & ~stuff;
	wire line_bit  = (state_reg == sft_pkg::ST_CRC) ? ~crc_q[0] : sh_reg[0];
	wire [4:0] data_len = `SFT_LEN_BASE + {3'b000, char_len};

	wire cts_change = cts_q_reg != cts_n;
	wire dcd_change = dcd_q_reg != dcd_n;
	wire empty_evt  = (take_data & armed_reg) | take_crc_end;

	////////////////////////////////////////////////////////////////////////////////
	sft_crc16 u_crc (
		.clk    (clk),
		.rst_n  (rst_n),
		.preset (cmd_reset_crc),
		.calc   (shift_bit & (state_reg == sft_pkg::ST_DATA)),
		.emit   (shift_bit & (state_reg == sft_pkg::ST_CRC)),
		.din    (sh_reg[0]),
		.crc_q  (crc_q)
	);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		sh_next    = sh_reg;
		left_next  = left_reg;
		if (!link_on) begin
			// Dropping the link mid-frame abandons it; line idles at mark
			state_next = sft_pkg::ST_IDLE;
			left_next  = 5'h00;
		end else if (take_abort) begin
			state_next = sft_pkg::ST_ABORT;
			sh_next    = `SFT_ABORT_CHAR;
			left_next  = `SFT_CHAR_BITS;
		end else if (take_data) begin
			state_next = sft_pkg::ST_DATA;
			sh_next    = buf_reg;
			left_next  = data_len;
		end else if (take_underrun) begin
			state_next = sft_pkg::ST_CRC;
			left_next  = `SFT_CRC_BITS;
		end else if (take_flag | take_crc_end) begin
			state_next = sft_pkg::ST_FLAG;
			sh_next    = `SFT_FLAG_CHAR;
			left_next  = `SFT_CHAR_BITS;
		end else if (shift_bit) begin
			sh_next   = {1'b1, sh_reg[7:1]};
			left_next = left_reg - 5'h01;
		end
	end

	always_comb begin
		txd_next = txd;
		if (!link_on) begin
			txd_next = 1'b1;
		end else if (stuff) begin
			txd_next = 1'b0;
		end else if (shift_bit) begin
			txd_next = line_bit;
		end
	end

	// Hardware set wins over a clear in the same cycle
	assign latch_next    = take_underrun | (transmit_underrun_end_latch & ~cmd_reset_underrun);
	assign tx_pend_next  = (empty_evt & tx_int_enable) | (tx_int_pending & ~cmd_reset_tx_int);
	assign ext_pend_next = (ext_int_enable & (cts_change | dcd_change
	                     | (latch_next != transmit_underrun_end_latch)))
	                     | (ext_int_pending & ~cmd_reset_ext_int);

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= sft_pkg::ST_IDLE;
			sh_reg    <= 8'hFF;
			left_reg  <= 5'h00;
			txd       <= 1'b1;
		end else begin
			state_reg <= state_next;
			sh_reg    <= sh_next;
			left_reg  <= left_next;
			txd       <= txd_next;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ones_reg <= 3'h0;
		end else if (~link_on | stuff | (shift_bit & ~line_bit) | (shift_bit & ~in_frame)) begin
			ones_reg <= 3'h0;
		end else if (shift_bit) begin
			ones_reg <= ones_reg + 3'h1;
		end
	end

	// Overwriting a full buffer replaces the byte; the host is paced by the requests
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			buf_reg        <= 8'h00;
			tx_buffer_full <= 1'b0;
		end else begin
			if (host_write) begin
				buf_reg <= host_data;
			end
			tx_buffer_full <= host_write | (tx_buffer_full & ~take_data);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			abort_pend_reg <= 1'b0;
			armed_reg      <= 1'b0;
		end else begin
			abort_pend_reg <= link_on & (cmd_send_abort | (abort_pend_reg & ~take_abort));
			armed_reg      <= tx_enable & (armed_reg | (host_write & link_on));
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			transmit_underrun_end_latch <= `SFT_LATCH_RESET;
			tx_int_pending              <= 1'b0;
			ext_int_pending             <= 1'b0;
			int_n                       <= 1'b1;
			wait_ready_n                <= 1'b1;
			cts_q_reg                   <= 1'b1;
			dcd_q_reg                   <= 1'b1;
		end else begin
			transmit_underrun_end_latch <= latch_next;
			tx_int_pending              <= tx_pend_next;
			ext_int_pending             <= ext_pend_next;
			int_n                       <= ~(tx_pend_next | ext_pend_next);
			wait_ready_n                <= ~(wait_mode & armed_reg & link_on
			                             & ~(host_write | (tx_buffer_full & ~take_data)));
			cts_q_reg                   <= cts_n;
			dcd_q_reg                   <= dcd_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_crc_done;
		(state_reg == sft_pkg::ST_CRC) && load_go && !abort_pend_reg;
	endsequence

	sequence s_flag_loaded;
		(state_reg == sft_pkg::ST_FLAG) && (sh_reg == `SFT_FLAG_CHAR) && (left_reg == 5'h08);
	endsequence

	a_opening_flag: assert property (take_flag |=> s_flag_loaded)
		else $error("flag not loaded on idle link");
	a_no_early_int: assert property ((!armed_reg && state_reg != sft_pkg::ST_CRC)
		|=> !$rose(tx_int_pending))
		else $error("buffer-empty interrupt before first byte");
	a_empty_request: assert property ((take_data && armed_reg && tx_int_enable)
		|=> tx_int_pending && !int_n)
		else $error("no buffer-empty request after byte move");
	a_len_loaded: assert property (take_data && !cmd_send_abort
		|=> left_reg == 5'h05 + {3'b000, $past(char_len)})
		else $error("character length not applied");
	a_underrun_crc: assert property (take_underrun
		|=> state_reg == sft_pkg::ST_CRC && transmit_underrun_end_latch ##0 left_reg == 5'h10)
		else $error("underrun did not start check sequence");
	a_crc_then_flag: assert property (s_crc_done |=> s_flag_loaded)
		else $error("closing flag missing after check sequence");
	a_closing_int: assert property (s_crc_done ##0 tx_int_enable |=> tx_int_pending)
		else $error("no buffer-empty interrupt at frame end");
	a_abort_ones: assert property (take_abort
		|=> state_reg == sft_pkg::ST_ABORT && sh_reg == 8'hFF)
		else $error("abort not sent");
	a_crc_preset: assert property (cmd_reset_crc |=> crc_q == 16'hFFFF)
		else $error("check accumulator not preset");
	a_ext_change: assert property ((ext_int_enable && (cts_change || dcd_change))
		|=> ext_int_pending)
		else $error("modem change missed");
	a_stuff_zero: assert property (stuff |=> !txd && ones_reg == 3'h0)
		else $error("zero not inserted");

endmodule

// ==== sft_line_station.sv ====
`timescale 1ns/1ps

module sft_line_station (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Serial line
	input  wire logic        txd,
	output logic             bit_tick,
	// Received frames
	output logic             frame_done,
	output logic [6:0]       frame_len,
	output logic [63:0]      frame_bits,
	output int               flag_cnt,
	output int               abort_cnt
);
	logic [1:0]  div;
	logic [7:0]  raw;
	logic [63:0] hist;
	logic [6:0]  nb;
	logic [3:0]  ones;
	logic        hunt;

	////////////////////////////////////////////////////////////////
	// Line clock runs free, one tick every four cycles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div <= 2'h0;
			bit_tick <= 1'b0;
			frame_done <= 1'b0;
			frame_len <= 7'h00;
			frame_bits <= 64'h0;
			flag_cnt <= 0;
			abort_cnt <= 0;
			raw <= 8'h00;
			hist <= 64'h0;
			nb <= 7'h00;
			ones <= 4'h0;
			hunt <= 1'b1;
		end else begin
			div <= div + 2'h1;
			bit_tick <= (div == 2'h3);
			frame_done <= 1'b0;
			if (bit_tick) begin
				raw <= {txd, raw[7:1]};
				ones <= !txd ? 4'h0 : (ones == 4'hF) ? ones : ones + 4'h1;
				if ({txd, raw[7:1]} == 8'h7E) begin
					// Frame closes; flag bits sit above the frame bits
					// Bits gathered while hunting belong to no frame
					frame_done <= !hunt;
					hunt <= 1'b0;
					frame_len <= nb - 7'h07;
					frame_bits <= {txd, hist[63:1]} >> (7'h3F - nb);
					flag_cnt <= flag_cnt + 1;
					nb <= 7'h00;
				end else if (txd && ones == 4'h6) begin
					abort_cnt <= abort_cnt + 1;
					hunt <= 1'b1;
					nb <= 7'h00;
				end else if (!(ones == 4'h5 && !txd)) begin
					// Inserted zero dropped above; idle ones saturate the count
					hist <= {txd, hist[63:1]};
					nb <= (nb == 7'h60) ? nb : nb + 7'h01;
				end
			end
		end
	end
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
`include "sft_regs.svh"

module testbench;
	logic        clk = 1'b0;
	logic        rst_n, tx_enable, wait_mode, host_write, cts_n, dcd_n, bit_tick, txd;
	logic        tx_buffer_full, transmit_underrun_end_latch, tx_int_pending;
	logic        ext_int_pending, int_n, wait_ready_n, frame_done;
	logic        tx_int_en, ext_int_en;
	logic [1:0]  char_len;
	logic [7:0]  host_data, rnd, b0;
	logic [4:0]  cmds;
	logic [6:0]  frame_len, l;
	logic [63:0] frame_bits, e;
	logic [63:0] exp_q[$];
	logic [6:0]  len_q[$];
	int          flag_cnt, abort_cnt, errors, check_count, a0;

	always #4 clk = ~clk;

	sft_transmitter u_sft_transmitter (.clk(clk), .rst_n(rst_n), .tx_enable(tx_enable),
		.tx_int_enable(tx_int_en), .ext_int_enable(ext_int_en), .wait_mode(wait_mode),
		.char_len(char_len), .host_write(host_write), .host_data(host_data),
		.cmd_reset_crc(cmds[0]), .cmd_reset_underrun(cmds[1]), .cmd_reset_tx_int(cmds[2]),
		.cmd_reset_ext_int(cmds[3]), .cmd_send_abort(cmds[4]), .cts_n(cts_n),
		.dcd_n(dcd_n), .bit_tick(bit_tick), .txd(txd), .tx_buffer_full(tx_buffer_full),
		.transmit_underrun_end_latch(transmit_underrun_end_latch),
		.tx_int_pending(tx_int_pending), .ext_int_pending(ext_int_pending),
		.int_n(int_n), .wait_ready_n(wait_ready_n));

	sft_line_station u_sft_line_station (.clk(clk), .rst_n(rst_n), .txd(txd),
		.bit_tick(bit_tick), .frame_done(frame_done), .frame_len(frame_len),
		.frame_bits(frame_bits), .flag_cnt(flag_cnt), .abort_cnt(abort_cnt));

	////////////////////////////////////////////////////////////////
	task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task test_done;
		if (errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Bounded wait; a hang ends the run as a failure
	task wait_on(input int sel, input logic val);
		logic s;
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk);
			#1;
			case (sel)
				0: s = tx_buffer_full;
				1: s = tx_int_pending;
				2: s = ext_int_pending;
				3: s = transmit_underrun_end_latch;
				4: s = (flag_cnt >= a0 + 2);
				5: s = (abort_cnt > a0);
				default: s = (len_q.size() == 0);
			endcase
			if (s === val)
				return;
		end
		errors++;
		test_done;
	endtask

	task pulse(input logic [4:0] m);
		@(posedge clk) cmds <= m;
		@(posedge clk) cmds <= 5'h00;
	endtask

	task write(input logic [7:0] d);
		@(posedge clk) begin
			host_write <= 1'b1;
			host_data <= d;
		end
		@(posedge clk) host_write <= 1'b0;
	endtask

	function logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d, input int n);
		logic fb;
		for (int i = 0; i < n; i++) begin
			fb = c[0] ^ d[i];
			c = c >> 1;
			if (fb)
				c = c ^ `SFT_CRC_POLY;
		end
		return c;
	endfunction

	function logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction

	// Two-byte frame, second byte in the character length l1
	task send_frame(input logic [7:0] d0, input logic [7:0] d1, input logic [1:0] l1,
		input logic use_crc, input logic wm);
		int n1;
		logic [15:0] c;
		n1 = 5 + l1;
		@(posedge clk) begin
			wait_mode <= wm;
			char_len <= 2'h3;
		end
		if (use_crc)
			pulse(5'h03);
		pulse(5'h0C);
		write(d0);
		wait_on(0, 1'b0);
		check("byte request", wm ? {63'h0, ~wait_ready_n} : {63'h0, tx_int_pending}, 64'h1);
		@(posedge clk) char_len <= l1;
		write(d1);
		c = crc_upd(crc_upd(`SFT_CRC_PRESET, d0, 8), d1, n1);
		e = 64'(d0) | (64'(d1 & ((8'h01 << n1) - 8'h01)) << 8);
		if (use_crc)
			e = e | ((64'(c) ^ 64'hFFFF) << (8 + n1));
		exp_q.push_back(e);
		len_q.push_back(7'(use_crc ? 24 + n1 : 8 + n1));
		wait_on(0, 1'b0);
		pulse(5'h0C);
		if (use_crc) begin
			wait_on(3, 1'b1);
			wait_on(2, 1'b1);
			wait_on(1, 1'b1);
		end
		pulse(5'h0C);
		wait_on(6, 1'b1);
	endtask

	////////////////////////////////////////////////////////////////
	// Frames seen on the line against the oldest note
	always @(posedge clk) begin
		if (frame_done && frame_len != 7'h00) begin
			if (len_q.size() == 0)
				check("unexpected frame", 64'(frame_len), 64'h0);
			else begin
				l = len_q.pop_front();
				e = exp_q.pop_front();
				check("frame length", 64'(frame_len), 64'(l));
				check("frame bits", frame_bits & ((64'h1 << l) - 64'h1), e);
			end
		end
	end

	initial begin
		{rst_n, tx_enable, wait_mode, host_write, char_len, host_data, cmds} = '0;
		{cts_n, dcd_n, rnd} = {2'b11, 8'h40};
		{tx_int_en, ext_int_en} = 2'b11;
		errors = 0;
		check_count = 0;
		a0 = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk) {tx_enable, cts_n} <= 2'b10;
		a0 = flag_cnt;
		wait_on(2, 1'b1);
		check("tx irq first", {63'h0, tx_int_pending}, 64'h0);
		check("int line", {63'h0, int_n}, 64'h0);
		wait_on(4, 1'b1);
		for (int k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			b0 = (rnd == `SFT_FLAG_CHAR) ? 8'h7D : rnd;
			rnd = lfsr(rnd);
			if (rnd == `SFT_FLAG_CHAR)
				rnd = 8'h7D;
			send_frame(k == 0 ? 8'hFF : b0, rnd, 2'(k), 1'b1, 1'(k));
		end
		// Latch still set: underrun closes without a check sequence
		send_frame(b0, rnd, 2'h3, 1'b0, 1'b0);
		pulse(5'h08);
		#1;
		check("ext irq cleared", {63'h0, ext_int_pending}, 64'h0);
		@(posedge clk) dcd_n <= 1'b0;
		wait_on(2, 1'b1);
		pulse(5'h03);
		write(8'h5A);
		wait_on(0, 1'b0);
		a0 = abort_cnt;
		pulse(5'h10);
		wait_on(5, 1'b1);
		// Wind down: interrupts off, then modem line moved and transmitter off in the same cycle
		@(posedge clk) {tx_int_en, ext_int_en} <= 2'b00;
		pulse(5'h0C);
		@(posedge clk) begin
			dcd_n <= 1'b1;
			tx_enable <= 1'b0;
		end
		repeat (2) @(posedge clk);
		#1;
		check("ext irq masked", {63'h0, ext_int_pending}, 64'h0);
		check("int line released", {63'h0, int_n}, 64'h1);
		check("line idles at mark", {63'h0, txd}, 64'h1);
		test_done;
	end
endmodule
